// File: design/rwtm_map.vh
// constants for the rf wake-up timer mode block
`ifndef RWTM_MAP_VH
`define RWTM_MAP_VH
// auto_cycle_mode_select encodings
`define RWTM_MODE_WOT       2'h0
`define RWTM_MODE_WOR       2'h1
// interrupt flag bit positions
`define RWTM_IRQ_TX_BIT     0
`define RWTM_IRQ_RX_BIT     1
// reset values
`define RWTM_PERIOD_RST     16'h0000
`define RWTM_IRQ_RST        2'h0
// activity codes reported on ACTIVITY_OUT
`define RWTM_ACT_IDLE       2'h0
`define RWTM_ACT_WOT        2'h1
`define RWTM_ACT_WOR        2'h2
`define RWTM_ACT_SLEEP      2'h3
`endif

// File: design/rwtm_top.v
// rf wake-up timer mode: periodic io waveform, wake mode select, irq flags
`timescale 1ns/10ps
`include "rwtm_map.vh"
// one clock; the slow timer clocks arrive as plain levels and are edge
// detected here, so their rate must stay well below half of MCLK_IN.
// wake-tx/rx only pulse WAKE_TICK_OUT; the packet engine lives elsewhere.
module rwtm_top #(
  parameter CNT_W = 16
) (
  input  wire             MCLK_IN,
  input  wire             RST_N_IN,
  input  wire             AUTO_CYCLE_ENABLE_IN,
  input  wire [1:0]       AUTO_CYCLE_MODE_SELECT_IN,
  input  wire [CNT_W-1:0] WAKE_PERIOD_COUNT_IN,
  input  wire             TIMER_CLOCK_SELECT_IN,
  input  wire             INTERNAL_SLOW_OSCILLATOR_IN,
  input  wire             EXTERNAL_SLOW_CLOCK_IN,
  input  wire             IDLE_STROBE_IN,
  input  wire             LIGHT_SLEEP_STROBE_IN,
  input  wire             TX_DONE_IN,
  input  wire             RX_PACKET_VALID_IN,
  input  wire             IRQ_FLAG_WRITE_IN,
  input  wire [1:0]       IRQ_FLAG_WDATA_IN,
  output reg              WAKE_TIMER_MODE_OUT,
  output reg  [1:0]       ACTIVITY_OUT,
  output reg              GENERAL_IO_LINE_OUT,
  output reg              IRQ_IO_LINE_OUT,
  output reg  [1:0]       IRQ_FLAG_REGISTER_OUT,
  output reg              WAKE_TICK_OUT
);

  // ************************************************
  // mode decode and run state
  // ************************************************
  localparam ST_SLEEP = 2'h0;
  localparam ST_RUN   = 2'h1;

  reg  [1:0]       state_r;
  reg  [1:0]       state_nxt;
  wire             wtm_sel;
  wire             wake_sel;

  assign wtm_sel  = AUTO_CYCLE_ENABLE_IN & AUTO_CYCLE_MODE_SELECT_IN[1];
  assign wake_sel = AUTO_CYCLE_ENABLE_IN & ~AUTO_CYCLE_MODE_SELECT_IN[1];

  // sleep strobe wins if both strobes arrive together
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_SLEEP: begin
        if (IDLE_STROBE_IN && !LIGHT_SLEEP_STROBE_IN && AUTO_CYCLE_ENABLE_IN) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (LIGHT_SLEEP_STROBE_IN || !AUTO_CYCLE_ENABLE_IN) begin
          state_nxt = ST_SLEEP;
        end
      end
      default: begin
        state_nxt = ST_SLEEP;
      end
    endcase
  end

  // ************************************************
  // slow clock select and edge detect
  // ************************************************
  // slow clocks are sampled as plain inputs; edges are counted in MCLK domain
  reg              slow_d_r;
  wire             slow_lvl;
  wire             slow_tick;

  assign slow_lvl  = TIMER_CLOCK_SELECT_IN ? EXTERNAL_SLOW_CLOCK_IN
                                           : INTERNAL_SLOW_OSCILLATOR_IN;
  assign slow_tick = slow_lvl & ~slow_d_r;

  // ************************************************
  // wake period counter
  // ************************************************
  reg  [CNT_W-1:0] cnt_r;
  reg  [CNT_W-1:0] cnt_nxt;
  wire             running;
  wire             expire;

  assign running = (state_r == ST_RUN);
  assign expire  = running && slow_tick && (cnt_r == {CNT_W{1'b0}});

  // count down on slow edges; reload on start and at expiry
  always @* begin
    cnt_nxt = cnt_r;
    if (!running) begin
      cnt_nxt = WAKE_PERIOD_COUNT_IN;
    end else if (expire) begin
      cnt_nxt = WAKE_PERIOD_COUNT_IN;
    end else if (slow_tick) begin
      cnt_nxt = cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // ************************************************
  // interrupt flags
  // ************************************************
  reg  [1:0]       irq_nxt;

  // a new event in the clearing cycle survives the write
  always @* begin
    irq_nxt = IRQ_FLAG_REGISTER_OUT;
    if (IRQ_FLAG_WRITE_IN) begin
      irq_nxt = IRQ_FLAG_REGISTER_OUT & IRQ_FLAG_WDATA_IN;
    end
    if (TX_DONE_IN) begin
      irq_nxt[`RWTM_IRQ_TX_BIT] = 1'b1;
    end
    if (RX_PACKET_VALID_IN) begin
      irq_nxt[`RWTM_IRQ_RX_BIT] = 1'b1;
    end
  end

  // ************************************************
  // output next values
  // ************************************************
  reg              will_run;
  reg              wtm_nxt;
  reg  [1:0]       act_nxt;
  reg              gio_nxt;
  reg              tick_nxt;

  // outputs follow the state being entered, so mode, activity and io line
  // all change on the same edge as the strobe that caused the change
  always @* begin
    will_run = (state_nxt == ST_RUN);
    wtm_nxt  = will_run && wtm_sel;
    act_nxt  = `RWTM_ACT_SLEEP;
    gio_nxt  = 1'b0;
    tick_nxt = 1'b0;
    // timer mode keeps the radio idle between and at expiries
    if (will_run) begin
      if (wtm_sel) begin
        act_nxt = `RWTM_ACT_IDLE;
      end else if (AUTO_CYCLE_MODE_SELECT_IN == `RWTM_MODE_WOR) begin
        act_nxt = `RWTM_ACT_WOR;
      end else begin
        act_nxt = `RWTM_ACT_WOT;
      end
    end
    // square wave: half period equals the programmed count plus one;
    // the line parks low outside timer mode so a host sees no stray edge
    if (wtm_nxt) begin
      if (expire) begin
        gio_nxt = ~GENERAL_IO_LINE_OUT;
      end else begin
        gio_nxt = GENERAL_IO_LINE_OUT;
      end
    end
    // wake pulse to the packet engine only in wake-tx/rx modes
    if (will_run && wake_sel) begin
      tick_nxt = expire;
    end
  end

  // ************************************************
  // control registers
  // ************************************************
  // run state, slow clock history and period counter; the reset branch
  // loads constants only, so nothing asynchronous reaches the datapath
  always @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_r  <= ST_SLEEP;
      slow_d_r <= 1'b0;
      cnt_r    <= `RWTM_PERIOD_RST;
    end else begin
      state_r  <= state_nxt;
      slow_d_r <= slow_lvl;
      cnt_r    <= cnt_nxt;
    end
  end

  // ************************************************
  // output registers
  // ************************************************
  // mode report; activity shows sleep out of reset
  always @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      WAKE_TIMER_MODE_OUT <= 1'b0;
      ACTIVITY_OUT        <= `RWTM_ACT_SLEEP;
    end else begin
      WAKE_TIMER_MODE_OUT <= wtm_nxt;
      ACTIVITY_OUT        <= act_nxt;
    end
  end

  // io waveform and wake pulse, both straight from flip-flops
  always @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      GENERAL_IO_LINE_OUT <= 1'b0;
      WAKE_TICK_OUT       <= 1'b0;
    end else begin
      GENERAL_IO_LINE_OUT <= gio_nxt;
      WAKE_TICK_OUT       <= tick_nxt;
    end
  end

  // flags and the io line that mirrors them; the line uses the next flag
  // value so it rises on the same edge as the flag itself
  always @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      IRQ_FLAG_REGISTER_OUT <= `RWTM_IRQ_RST;
      IRQ_IO_LINE_OUT       <= 1'b0;
    end else begin
      IRQ_FLAG_REGISTER_OUT <= irq_nxt;
      IRQ_IO_LINE_OUT       <= |irq_nxt;
    end
  end

endmodule

// File: dv/rwtm_top_assertions.sv
// assertions for the rf wake-up timer mode block
`timescale 1ns/10ps
module rwtm_chk (
  input wire       MCLK_IN,
  input wire       RST_N_IN,
  input wire       AUTO_CYCLE_ENABLE_IN,
  input wire [1:0] AUTO_CYCLE_MODE_SELECT_IN,
  input wire       IDLE_STROBE_IN,
  input wire       LIGHT_SLEEP_STROBE_IN,
  input wire       TX_DONE_IN,
  input wire       RX_PACKET_VALID_IN,
  input wire       IRQ_FLAG_WRITE_IN,
  input wire [1:0] IRQ_FLAG_WDATA_IN,
  input wire       WAKE_TIMER_MODE_OUT,
  input wire [1:0] ACTIVITY_OUT,
  input wire       IRQ_IO_LINE_OUT,
  input wire [1:0] IRQ_FLAG_REGISTER_OUT,
  input wire       GENERAL_IO_LINE_OUT,
  input wire       WAKE_TICK_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // sleep wins over idle, so a start only counts without it
  wire       go = IDLE_STROBE_IN & AUTO_CYCLE_ENABLE_IN & ~LIGHT_SLEEP_STROBE_IN;
  wire       clr = IRQ_FLAG_WRITE_IN & ~|IRQ_FLAG_WDATA_IN & ~TX_DONE_IN & ~RX_PACKET_VALID_IN;
  wire [1:0] m = AUTO_CYCLE_MODE_SELECT_IN;
  wire [2:0] st = {WAKE_TIMER_MODE_OUT, ACTIVITY_OUT};
  wire [2:0] fl = {IRQ_IO_LINE_OUT, IRQ_FLAG_REGISTER_OUT};
  start_wtm_a: assert property (go && m[1] |=> st == 3'h4) else $error("no start");
  stop_wtm_a: assert property (LIGHT_SLEEP_STROBE_IN |=> st == 3'h3) else $error("no stop");
  pick_wot_a: assert property (go && m == 2'h0 |=> st == 3'h1) else $error("bad wot");
  pick_wor_a: assert property (go && m == 2'h1 |=> st == 3'h2) else $error("bad wor");
  stay_idle_a: assert property (st[2] |-> st[1:0] == 2'h0) else $error("not idle");
  tx_flag_a: assert property (TX_DONE_IN |=> fl[0] && fl[2]) else $error("no tx flag");
  rx_flag_a: assert property (RX_PACKET_VALID_IN |=> fl[1] && fl[2]) else $error("no rx");
  flag_clr_a: assert property (clr |=> fl == 3'h0) else $error("no clear");
  io_quiet_a: assert property (!st[2] |-> !GENERAL_IO_LINE_OUT) else $error("io not low");
  tick_quiet_a: assert property (st[2] |-> !WAKE_TICK_OUT) else $error("tick in wtm");
endmodule
bind rwtm_top rwtm_chk i_chk (.*);

// File: dv/rwtm_host.sv
// host model issuing strobes and flag clear writes
`timescale 1ns/10ps
module rwtm_host (
  input  wire       clk_in,
  output reg  [2:0] cmd_out = 3'h0,
  output reg  [1:0] wdata_out = 2'h0
);
  // one-cycle command: 4 idle, 2 light sleep, 1 flag write
  task pulse(input [2:0] c);
    begin
      @(negedge clk_in);
      cmd_out = c;
      @(negedge clk_in);
      cmd_out = 3'h0;
    end
  endtask
  // flag write: the mask is and-ed into the flags, zero clears them all
  task flag_write(input [1:0] d);
    begin
      wdata_out = d;
      pulse(3'h1);
    end
  endtask
endmodule

// File: dv/rwtm_top_tb_top.sv
// testbench for the rf wake-up timer mode block
`timescale 1ns/10ps
module rwtm_top_tb_top;
  reg        clk = 1'b0;
  reg        rst_n = 1'b0;
  reg  [3:0] div = 4'h0;
  reg  [5:0] ctl = 6'h0;
  reg  [15:0] per = 16'h0002;
  wire [2:0] cmd;
  wire [1:0] wd, act, fl;
  wire       wake_timer_mode, general_io_line, irq, tick;
  integer    num_errors = 0, n_compared = 0, cyc = 0, n;
  rwtm_host h (.clk_in(clk), .cmd_out(cmd), .wdata_out(wd));
  rwtm_top i_dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .AUTO_CYCLE_ENABLE_IN(ctl[2]),
    .AUTO_CYCLE_MODE_SELECT_IN(ctl[1:0]), .WAKE_PERIOD_COUNT_IN(per),
    .TIMER_CLOCK_SELECT_IN(ctl[3]), .INTERNAL_SLOW_OSCILLATOR_IN(div[1]),
    .EXTERNAL_SLOW_CLOCK_IN(div[2]), .IDLE_STROBE_IN(cmd[2]), .LIGHT_SLEEP_STROBE_IN(cmd[1]),
    .TX_DONE_IN(ctl[5]), .RX_PACKET_VALID_IN(ctl[4]), .IRQ_FLAG_WRITE_IN(cmd[0]),
    .IRQ_FLAG_WDATA_IN(wd), .WAKE_TIMER_MODE_OUT(wake_timer_mode), .ACTIVITY_OUT(act),
    .GENERAL_IO_LINE_OUT(general_io_line), .IRQ_IO_LINE_OUT(irq), .IRQ_FLAG_REGISTER_OUT(fl),
    .WAKE_TICK_OUT(tick));
  initial forever #25 clk = ~clk;
  // slow clocks run free: internal every 4 cycles, external every 8
  always @(negedge clk) div <= div + 4'h1;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors = num_errors + 1;
      summarize;
    end
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // cycles until the io line changes, bounded so a dead line cannot hang
  task tog(output integer k);
    reg g;
    begin
      g = general_io_line;
      k = 0;
      while (general_io_line === g && k < 200) begin
        @(negedge clk);
        k = k + 1;
      end
    end
  endtask
  // cycles up to the next wake pulse, bounded so a dead pulse cannot hang
  task wait_tick(output integer k);
    begin
      @(negedge clk);
      k = 1;
      while (tick !== 1'b1 && k < 200) begin
        @(negedge clk);
        k = k + 1;
      end
    end
  endtask
  // wake-transmit pulses every 3 slow edges with no io waveform; enable
  // low stops it
  task t_tick;
    begin
      per = 16'h0002;
      ctl[3:0] = 4'h4;
      h.pulse(3'h4);
      wait_tick(n);
      wait_tick(n);
      chk(n, 12);
      chk({wake_timer_mode, act, general_io_line}, 2);
      ctl[2] = 1'b0;
      @(negedge clk);
      chk({wake_timer_mode, act, tick}, 6);
    end
  endtask
  // wake-transmit, wake-receive, then a start refused with enable low
  task t_mode;
    for (n = 0; n < 3; n = n + 1) begin
      ctl[2:0] = {n != 2, 1'b0, n[0]};
      h.pulse(3'h4);
      chk({wake_timer_mode, act}, n + 1);
      h.pulse(3'h2);
    end
  endtask
  // both flags set, a masked write, a clear racing a new event, a full clear
  task t_flag;
    begin
      ctl[5] = 1'b1;
      @(negedge clk);
      ctl[5:4] = 2'h1;
      @(negedge clk);
      ctl[4] = 1'b0;
      chk({irq, fl}, 7);
      h.flag_write(2'h1);
      chk({irq, fl}, 5);
      fork
        h.flag_write(2'h0);
        begin
          @(negedge clk);
          ctl[5] = 1'b1;
          @(negedge clk);
          ctl[5] = 1'b0;
        end
      join
      chk({irq, fl}, 5);
      h.flag_write(2'h0);
      chk({irq, fl}, 0);
    end
  endtask
  // timer mode on one source; a count of p expires every p+1 slow edges
  task t_wtm(input c, input [15:0] p, input integer exp);
    begin
      per = p;
      ctl[3:0] = {c, 3'h6};
      h.pulse(3'h4);
      chk({wake_timer_mode, act}, 4);
      tog(n);
      tog(n);
      chk(n, exp);
      h.pulse(3'h2);
      chk({wake_timer_mode, act, general_io_line}, 6);
    end
  endtask
  task summarize;
    begin
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    t_mode;
    t_flag;
    t_tick;
    t_wtm(1'b0, 16'h0002, 12);
    t_wtm(1'b1, 16'h0001, 16);
    summarize;
  end
endmodule
